// ---- core/self_test_pkg.sv ----
// Constants, failure codes and test numbers for the pod self-test fault classifier
//
// Notes on behaviour
// R01 - Writing a test number to the test-select address runs that test once.
// R02 - High-address test disables low latches, enables high latch; high standby enable held.
// R03 - Data, address latch and data latch all differ from address: code 05.
// R04 - Only the address latch differs from the address: code 06.
// R05 - Address latch right, data and data latch both wrong but equal to each other, or byte latch wrong: 07.
// R06 - Data latch matches address but the read data differs: code 08.
// R07 - Data latch matches neither address nor returned data: code 09.
// R08 - High-order address latch differs from the address: code 0A.
// R09 - Byte reads compare only the low byte of data with the address low byte.
// R10 - Returned data differs from address high byte: code 0B.
// R11 - Address latch and data latch are each readable at their own address.
// R12 - Output buffer test writes six patterns to address zero; mismatch gives 0C.
// R13 - Neither status nor control latch right: code 0D; last status readable.
// R14 - Status right but control latch wrong: code 0E.
// R15 - Control latch right but status latch wrong: code 0F.
// R16 - Enableable lines driven to both states and captured, else code 10.
// R17 - Each sync mode selected and sync line latched; wrong capture gives 11.
// R18 - With high standby enable on, latches capture standby address, else 12.
// R19 - Control bits wrong after interrupt acknowledge: code 16.
// R20 - Fetch with interrupt status high must bring an acknowledge, else 17.
// R21 - Power-fail cycle must raise non-maskable interrupt, else 19.
// R22 - On low power stop talking to host and float outputs high, else 1B.
// R23 - No failure found reports code 00.
// R24 - Host disables self-test with FFBF and re-enables with FFFF.
// R25 - First failure code is held until the next test select or reset.
package self_test_pkg;

    localparam logic [31:0] test_select_addr = 32'hf000_0000;
    localparam logic [31:0] last_status_addr = 32'hf000_0052;
    localparam logic [31:0] self_test_ctl_addr = 32'hf000_0060;
    localparam logic [31:0] standby_read_addr = 32'h0800_f000;
    localparam logic [31:0] addr_latch_addr = 32'h0800_f400;
    localparam logic [31:0] data_latch_addr = 32'h0800_f600;

    localparam logic [15:0] self_test_off = 16'hffbf;
    localparam logic [15:0] self_test_on = 16'hffff;

    // Each test number equals a failure code; tests 05, 06, 08, 09 report any of 05-09, tests 0D-0F any of 0D-0F
    localparam logic [7:0] code_none = 8'h00;
    localparam logic [7:0] code_low_addr = 8'h05;
    localparam logic [7:0] code_addr_latch = 8'h06;
    localparam logic [7:0] code_low_line = 8'h07;
    localparam logic [7:0] code_data_in = 8'h08;
    localparam logic [7:0] code_data_latch = 8'h09;
    localparam logic [7:0] code_high_addr = 8'h0a;
    localparam logic [7:0] code_high_line = 8'h0b;
    localparam logic [7:0] code_data_out = 8'h0c;
    localparam logic [7:0] code_ctl_buf = 8'h0d;
    localparam logic [7:0] code_ctl_latch = 8'h0e;
    localparam logic [7:0] code_status_latch = 8'h0f;
    localparam logic [7:0] code_enableable = 8'h10;
    localparam logic [7:0] code_sync = 8'h11;
    localparam logic [7:0] code_standby = 8'h12;
    localparam logic [7:0] code_self_int = 8'h16;
    localparam logic [7:0] code_intr = 8'h17;
    localparam logic [7:0] code_nmi = 8'h19;
    localparam logic [7:0] code_low_power = 8'h1b;

    // Extended codes are decimal-looking: 0x1000 plus decimal of short code
    localparam logic [15:0] ext_base = 16'h1000;

    localparam int num_patterns = 6;
    localparam logic [15:0] out_patterns [num_patterns] = '{16'h0000, 16'hffff, 16'h5555,
        16'haaaa, 16'hcccc, 16'h3333};

    localparam int num_sync_modes = 4;
    localparam logic [2:0] sync_mode_last = 3'h3;

    // Cycles to wait for acknowledge or NMI
    localparam int wait_ns = 400;
    localparam int clk_period_ns = 4;
    localparam int wait_cycles = wait_ns / clk_period_ns;
    localparam logic [7:0] wait_count = 8'(wait_cycles);

    typedef enum logic [6:0] {
        st_idle = 7'b0000001,
        st_addr = 7'b0000010,
        st_data_out = 7'b0000100,
        st_ctl = 7'b0001000,
        st_step = 7'b0010000,
        st_wait = 7'b0100000,
        st_done = 7'b1000000
    } seq_state_t;

endpackage

// ---- core/pod_self_test.sv ----
// Self-test sequencer and failure classifier of the emulation pod
`timescale 1ns/1ps
module pod_self_test
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Host access
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [31:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    // Bus under test
    output logic bus_req,
    output logic bus_write,
    output logic bus_byte,
    output logic [23:0] bus_addr,
    output logic [15:0] bus_wdata,
    input wire logic bus_done,
    input wire logic [15:0] bus_rdata,
    input wire logic [23:0] addr_drv_latch,
    input wire logic [15:0] data_drv_latch,
    input wire logic [7:0] status_latch,
    input wire logic [7:0] control_latch,
    input wire logic [7:0] status_expect,
    input wire logic [7:0] control_expect,
    // Latch and line control
    output logic low_latch_en,
    output logic high_latch_en,
    output logic standby_out_enable_high,
    output logic standby_out_enable_low,
    output logic enableable_drive,
    output logic enableable_level,
    output logic [1:0] sync_mode,
    output logic int_enable,
    output logic code_or_int_ack_status,
    output logic power_fail_cycle,
    // Asynchronous pins, synchronised here
    input wire logic emulator_sync_line,
    input wire logic int_ack_seen,
    input wire logic nmi_seen,
    input wire logic low_power,
    // Outputs floating high under low power
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    // Results
    output logic self_test_enabled,
    output logic test_busy,
    output logic [7:0] fail_code,
    output logic [15:0] fail_code_ext
);

    // ==========================================
    // Pin synchronisers
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end
        else
        begin
            pin_meta <= {low_power, nmi_seen, int_ack_seen, emulator_sync_line};
            pin_sync <= pin_meta;
        end
    end
    wire sync_s = pin_sync[0];
    wire ack_s = pin_sync[1];
    wire nmi_s = pin_sync[2];
    wire lowpwr_s = pin_sync[3];

    // ==========================================
    // Host decode
    wire sel_wr = host_wr && host_addr == self_test_pkg::test_select_addr && !lowpwr_s;
    wire ctl_wr = host_wr && host_addr == self_test_pkg::self_test_ctl_addr;

    // Powers up enabled; only the two documented words change it
    always_ff @(posedge mclk)
    begin
        if (reset)
            self_test_enabled <= 1'b1;
        else if (ctl_wr && host_wdata == self_test_pkg::self_test_off)
            self_test_enabled <= 1'b0;
        else if (ctl_wr && host_wdata == self_test_pkg::self_test_on)
            self_test_enabled <= 1'b1;
    end

    // ==========================================
    // Sequencer
    self_test_pkg::seq_state_t state;
    logic [7:0] test_num;
    logic [2:0] step;
    logic [7:0] wait_cnt;
    logic fail_seen;
    logic [7:0] last_status;

    // Expected data for address step: word tests use full pattern
    function automatic logic [15:0] pat(input logic [2:0] i);
        pat = self_test_pkg::out_patterns[i];
    endfunction

    // Classification of one read against the sent address
    function automatic logic [7:0] classify_word(input logic [15:0] a, input logic [15:0] d,
        input logic [15:0] al, input logic [15:0] dl);
        logic dm;
        logic am;
        logic lm;
        dm = d == a;
        am = al == a;
        lm = dl == a;
        classify_word = self_test_pkg::code_none;
        if (!dm && !am && !lm)
            classify_word = self_test_pkg::code_low_addr; // see R03
        else if (!am && dm && lm)
            classify_word = self_test_pkg::code_addr_latch; // see R04
        else if (lm && !dm)
            classify_word = self_test_pkg::code_data_in; // see R06
        else if (!lm && dl != d)
            classify_word = self_test_pkg::code_data_latch; // see R07
        else if (am && !dm && !lm)
            classify_word = self_test_pkg::code_low_line; // see R05
    endfunction

    logic [7:0] verdict;
    logic [15:0] sent;
    always_comb
    begin
        sent = pat(step);
        verdict = self_test_pkg::code_none;
        case (test_num)
            self_test_pkg::code_low_addr, self_test_pkg::code_addr_latch, self_test_pkg::code_data_in,
            self_test_pkg::code_data_latch:
                verdict = classify_word(sent, bus_rdata, addr_drv_latch[15:0], data_drv_latch);
            self_test_pkg::code_low_line:
                // Byte reads: only the low byte counts
                if (bus_rdata[7:0] != sent[7:0] || data_drv_latch[7:0] != sent[7:0])
                    verdict = self_test_pkg::code_low_line; // see R05, R09
            self_test_pkg::code_high_addr:
                if (addr_drv_latch[23:16] != sent[7:0])
                    verdict = self_test_pkg::code_high_addr; // see R08
            self_test_pkg::code_high_line:
                if (bus_rdata[7:0] != sent[7:0])
                    verdict = self_test_pkg::code_high_line; // see R10
            self_test_pkg::code_data_out:
                if (data_drv_latch != sent)
                    verdict = self_test_pkg::code_data_out; // see R12
            self_test_pkg::code_ctl_buf, self_test_pkg::code_ctl_latch, self_test_pkg::code_status_latch:
                if (status_latch != status_expect && control_latch != control_expect)
                    verdict = self_test_pkg::code_ctl_buf; // see R13
                else if (control_latch != control_expect)
                    verdict = self_test_pkg::code_ctl_latch; // see R14
                else if (status_latch != status_expect)
                    verdict = self_test_pkg::code_status_latch; // see R15
            self_test_pkg::code_enableable:
                if (status_latch[0] != step[0])
                    verdict = self_test_pkg::code_enableable; // see R16
            self_test_pkg::code_sync:
                if (sync_s != step[0])
                    verdict = self_test_pkg::code_sync; // see R17
            self_test_pkg::code_standby:
                if (addr_drv_latch != self_test_pkg::standby_read_addr[23:0])
                    verdict = self_test_pkg::code_standby; // see R18
            self_test_pkg::code_self_int:
                if (control_latch != control_expect)
                    verdict = self_test_pkg::code_self_int; // see R19
            default:
                verdict = self_test_pkg::code_none;
        endcase
    end

    wire [2:0] last_step = (test_num == self_test_pkg::code_enableable) ? 3'h1 :
        (test_num == self_test_pkg::code_sync) ? self_test_pkg::sync_mode_last :
        (test_num == self_test_pkg::code_ctl_buf || test_num == self_test_pkg::code_ctl_latch ||
         test_num == self_test_pkg::code_status_latch || test_num == self_test_pkg::code_standby ||
         test_num == self_test_pkg::code_self_int) ? 3'h0 :
        3'(self_test_pkg::num_patterns - 1);
    wire waits = test_num == self_test_pkg::code_intr || test_num == self_test_pkg::code_nmi ||
        test_num == self_test_pkg::code_low_power;
    wire wait_hit = (test_num == self_test_pkg::code_intr) ? ack_s :
        (test_num == self_test_pkg::code_nmi) ? nmi_s : lowpwr_s;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= self_test_pkg::st_idle;
            test_num <= 8'h00;
            step <= 3'h0;
            wait_cnt <= 8'h00;
        end
        else if (sel_wr && self_test_enabled)
        begin
            // A new select restarts the test, so repeats run it again
            state <= self_test_pkg::st_step; // see R01
            test_num <= host_wdata[7:0];
            step <= 3'h0;
            wait_cnt <= self_test_pkg::wait_count;
        end
        else
        begin
            case (state)
                self_test_pkg::st_step:
                    if (waits)
                        state <= self_test_pkg::st_wait;
                    else if (bus_done)
                    begin
                        if (step == last_step)
                            state <= self_test_pkg::st_done;
                        else
                            step <= step + 3'h1;
                    end
                self_test_pkg::st_wait:
                    if (wait_hit || wait_cnt == 8'h00)
                        state <= self_test_pkg::st_done;
                    else
                        wait_cnt <= wait_cnt - 8'h01;
                self_test_pkg::st_done:
                    state <= self_test_pkg::st_idle;
                default:
                    state <= self_test_pkg::st_idle;
            endcase
        end
    end

    // ==========================================
    // Access and line drive
    wire running = state == self_test_pkg::st_step || state == self_test_pkg::st_wait;
    wire byte_test = test_num == self_test_pkg::code_low_line || test_num == self_test_pkg::code_high_line;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            bus_req <= 1'b0;
            enableable_drive <= 1'b0;
            int_enable <= 1'b0;
            code_or_int_ack_status <= 1'b0;
            power_fail_cycle <= 1'b0;
        end
        else
        begin
            // Dropped a cycle after each answer so every access is a fresh request
            bus_req <= state == self_test_pkg::st_step && !waits && !bus_done && !(sel_wr && self_test_enabled);
            enableable_drive <= running && test_num == self_test_pkg::code_enableable; // see R16
            int_enable <= running && test_num == self_test_pkg::code_intr; // see R20
            code_or_int_ack_status <= running && test_num == self_test_pkg::code_intr; // see R20
            power_fail_cycle <= running && test_num == self_test_pkg::code_nmi; // see R21
        end
    end

    // Data-only registers, updated on the same edge that raises the request
    always_ff @(posedge mclk)
    begin
        bus_write <= test_num == self_test_pkg::code_data_out; // see R12
        bus_byte <= byte_test; // see R09
        if (test_num == self_test_pkg::code_standby)
            bus_addr <= self_test_pkg::standby_read_addr[23:0]; // see R18
        else if (test_num == self_test_pkg::code_data_out)
            bus_addr <= 24'h000000; // see R12
        else
            bus_addr <= {sent[7:0], sent};
        bus_wdata <= sent;
        enableable_level <= step[0]; // see R16
        sync_mode <= step[1:0]; // see R17
    end

    // ==========================================
    // Latch enables, busy and last status
    wire high_sel = host_wdata[7:0] == self_test_pkg::code_high_addr;
    wire standby_sel = high_sel || host_wdata[7:0] == self_test_pkg::code_standby;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            low_latch_en <= 1'b1;
            high_latch_en <= 1'b0;
            standby_out_enable_high <= 1'b0;
            standby_out_enable_low <= 1'b1;
            test_busy <= 1'b0;
            last_status <= 8'h00;
        end
        else
        begin
            test_busy <= (sel_wr && self_test_enabled) ||
                !(state == self_test_pkg::st_idle || state == self_test_pkg::st_done); // see R01
            if (state == self_test_pkg::st_step && bus_done)
                last_status <= status_latch; // see R13
            if (sel_wr && self_test_enabled)
            begin
                // Held until reset or the next select
                low_latch_en <= !high_sel; // see R02
                high_latch_en <= high_sel; // see R02
                standby_out_enable_high <= standby_sel; // see R02, R18
                standby_out_enable_low <= !standby_sel; // see R02
            end
        end
    end

    // ==========================================
    // Failure capture: first failure held
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            fail_code <= self_test_pkg::code_none; // see R23
            fail_code_ext <= 16'h0000;
            fail_seen <= 1'b0;
        end
        else if (sel_wr && self_test_enabled)
        begin
            fail_code <= self_test_pkg::code_none; // see R25
            fail_code_ext <= 16'h0000;
            fail_seen <= 1'b0;
        end
        else if (!fail_seen && state == self_test_pkg::st_step && bus_done && verdict != 8'h00)
        begin
            fail_code <= verdict; // see R25
            fail_code_ext <= self_test_pkg::ext_base + 16'(verdict / 8'd10 * 8'd16 + verdict % 8'd10);
            fail_seen <= 1'b1;
        end
        else if (!fail_seen && state == self_test_pkg::st_wait && !wait_hit && wait_cnt == 8'h00)
        begin
            fail_code <= test_num; // see R20, R21, R22
            fail_code_ext <= self_test_pkg::ext_base + 16'(test_num / 8'd10 * 8'd16 + test_num % 8'd10);
            fail_seen <= 1'b1;
        end
    end

    // ==========================================
    // Host read path; silent and floating high under low power
    logic [15:0] read_word;
    always_comb
    begin
        case (host_addr)
            self_test_pkg::last_status_addr: read_word = {8'h00, last_status}; // see R13
            self_test_pkg::addr_latch_addr: read_word = addr_drv_latch[15:0]; // see R11
            self_test_pkg::data_latch_addr: read_word = data_drv_latch; // see R11
            default: read_word = {8'h00, fail_code}; // see R25
        endcase
    end
    wire read_ok = host_rd && !lowpwr_s;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            host_rvalid <= 1'b0;
            host_data_oe <= 1'b0;
            host_data_out <= 16'hffff;
        end
        else
        begin
            host_rvalid <= read_ok; // see R22
            host_data_oe <= read_ok; // see R22
            host_data_out <= read_ok ? read_word : 16'hffff; // see R22
        end
    end
    always_ff @(posedge mclk)
    begin
        if (read_ok)
            host_rdata <= read_word; // see R11
    end

    // ==========================================
    // Assertions
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    a_select_busy: assert property (sel_wr && self_test_enabled |=> test_busy) // see R01
        else $error("Test select did not raise busy");
    a_done_idle: assert property (state == self_test_pkg::st_done && !sel_wr |=> !test_busy) // see R01
        else $error("Busy still set after test end");
    a_high_latches: assert property (test_num == self_test_pkg::code_high_addr |-> // see R02
        standby_out_enable_high && !standby_out_enable_low && high_latch_en && !low_latch_en)
        else $error("High address test latch enables wrong");
    a_fail_held: assert property (fail_seen && !sel_wr |=> $stable(fail_code)) // see R25
        else $error("Held failure code changed");
    a_no_fail_zero: assert property (!fail_seen |-> fail_code == self_test_pkg::code_none) // see R23
        else $error("Failure code without a failure");
    a_low_power_quiet: assert property (lowpwr_s |=> !host_data_oe && host_data_out == 16'hffff) // see R22
        else $error("Host data driven under low power");
    a_write_pattern: assert property (bus_req && test_num == self_test_pkg::code_data_out |-> // see R12
        bus_write && bus_addr == 24'h000000)
        else $error("Output buffer test not writing address zero");
    a_intr_drive: assert property (state == self_test_pkg::st_wait && test_num == self_test_pkg::code_intr |-> // see R20
        int_enable && code_or_int_ack_status)
        else $error("Interrupt test lines not driven");
endmodule

// ---- tb/pod_bus_model.sv ----
// Model of the pod buffers and latches answering the self-test sequencer
`timescale 1ns/1ps
module pod_bus_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Fault and pacing selection
    input wire logic [3:0] fault,
    input wire logic slow,
    // Bus under test
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [23:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic bus_done,
    output logic [15:0] bus_rdata,
    output logic [23:0] addr_drv_latch,
    output logic [15:0] data_drv_latch,
    // Latches and pins
    input wire logic [7:0] status_expect,
    input wire logic [7:0] control_expect,
    output logic [7:0] status_latch,
    output logic [7:0] control_latch,
    input wire logic code_or_int_ack_status,
    input wire logic int_enable,
    input wire logic power_fail_cycle,
    output logic int_ack_seen,
    output logic nmi_seen
);
logic [3:0] wait_cnt;
logic [15:0] good;
logic rd_bad;
// ==========
// Access timing
always_ff @(posedge mclk)
begin
    if (reset || !bus_req || bus_done)
    begin
        wait_cnt <= slow ? 4'h7 : 4'h0;
        bus_done <= 1'b0;
    end
    else if (wait_cnt == 4'h0)
        bus_done <= 1'b1;
    else
        wait_cnt <= wait_cnt - 4'h1;
end
// ==========
// Returned data and latches
always_comb
begin
    good = bus_write ? bus_wdata : bus_addr[15:0];
    rd_bad = fault == 4'h1 || fault == 4'h3 || fault == 4'h4;
    // Idle data is inverted so no stale value looks valid
    bus_rdata = (bus_done && !rd_bad) ? good : ~good;
    addr_drv_latch = (fault == 4'h1 || fault == 4'h2) ? ~bus_addr : bus_addr;
    data_drv_latch = (fault == 4'h1 || fault == 4'h3) ? ~good : good;
    if (fault == 4'h5)
        data_drv_latch = good ^ 16'h0f0f;
    status_latch = (fault == 4'h6 || fault == 4'h8) ? ~status_expect : status_expect;
    control_latch = (fault == 4'h6 || fault == 4'h7) ? ~control_expect : control_expect;
end
// ==========
// Interrupt pins
always_ff @(posedge mclk)
begin
    int_ack_seen <= !reset && code_or_int_ack_status && int_enable && fault != 4'h9;
    nmi_seen <= !reset && power_fail_cycle && fault != 4'ha;
end
endmodule

// ---- tb/pod_self_test_test.sv ----
// Self-checking bench of the pod self-test classifier
`timescale 1ns/1ps
module pod_self_test_test;
logic mclk, reset, host_wr, host_rvalid, bus_req, bus_write, bus_done;
logic [31:0] host_addr;
logic [15:0] host_wdata, host_rdata, bus_wdata, bus_rdata, data_drv_latch, host_data_out, fail_code_ext;
logic [23:0] bus_addr, addr_drv_latch;
logic [7:0] status_latch, control_latch, status_expect, control_expect, fail_code;
logic low_latch_en, high_latch_en, stoe_hi, stoe_lo, int_enable, cia, pfc, int_ack_seen, nmi_seen;
logic low_power, host_data_oe, self_test_enabled, test_busy, slow, host_rd;
logic [3:0] fault;
logic [15:0] lfsr;
int num_errors, cmp_count, cycles;
localparam logic [15:0] runs [18] = '{16'h0500, 16'h0501, 16'h0502, 16'h0503, 16'h0504, 16'h0505,
    16'h0a00, 16'h0a02, 16'h0c00, 16'h0c03, 16'h0d06, 16'h0d07, 16'h0d08, 16'h0d00, 16'h1700,
    16'h1709, 16'h1900, 16'h190a};
pod_self_test u_pod_self_test (.mclk(mclk), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .bus_req(bus_req), .bus_write(bus_write), .bus_byte(), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_done(bus_done), .bus_rdata(bus_rdata), .addr_drv_latch(addr_drv_latch),
    .data_drv_latch(data_drv_latch), .status_latch(status_latch), .control_latch(control_latch),
    .status_expect(status_expect), .control_expect(control_expect), .low_latch_en(low_latch_en),
    .high_latch_en(high_latch_en), .standby_out_enable_high(stoe_hi), .standby_out_enable_low(stoe_lo),
    .enableable_drive(), .enableable_level(), .sync_mode(), .int_enable(int_enable),
    .code_or_int_ack_status(cia), .power_fail_cycle(pfc), .emulator_sync_line(1'b0),
    .int_ack_seen(int_ack_seen), .nmi_seen(nmi_seen), .low_power(low_power),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .self_test_enabled(self_test_enabled),
    .test_busy(test_busy), .fail_code(fail_code), .fail_code_ext(fail_code_ext));
pod_bus_model u_pod_bus_model (.mclk(mclk), .reset(reset), .fault(fault), .slow(slow),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_done(bus_done), .bus_rdata(bus_rdata), .addr_drv_latch(addr_drv_latch),
    .data_drv_latch(data_drv_latch), .status_expect(status_expect), .control_expect(control_expect),
    .status_latch(status_latch), .control_latch(control_latch), .code_or_int_ack_status(cia),
    .int_enable(int_enable), .power_fail_cycle(pfc), .int_ack_seen(int_ack_seen), .nmi_seen(nmi_seen));
// ==========
// Reference model
function automatic logic [7:0] model_code(input logic [7:0] t, input logic [3:0] f);
    if (f == 4'h0)
        return 8'h00;
    if (t == 8'h05)
        return 8'h04 + 8'(f);
    if (t == 8'h0d)
        return 8'h07 + 8'(f);
    return t;
endfunction
function automatic logic [15:0] model_ext(input logic [7:0] c);
    if (c == 8'h00)
        return 16'h0000;
    return 16'h1000 + 16'((c / 8'h0a) * 8'h10 + c % 8'h0a);
endfunction
function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
// ==========
// Tasks
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
        num_errors++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic host_write(input logic [31:0] a, input logic [15:0] d);
    @(negedge mclk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge mclk);
    host_wr = 1'b0;
endtask
task automatic host_read(input logic [31:0] a, input logic [15:0] exp, input logic on);
    @(negedge mclk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge mclk);
    host_rd = 1'b0;
    check({15'h0000, host_rvalid}, {15'h0000, on});
    check({15'h0000, host_data_oe}, {15'h0000, on});
    check(host_data_out, on ? exp : 16'hffff);
    if (on)
        check(host_rdata, exp);
endtask
task automatic run_test(input logic [7:0] t, input logic [3:0] f);
    logic [7:0] exp;
    int n;
    exp = model_code(t, f);
    lfsr = lfsr_next(lfsr);
    fault = f;
    slow = lfsr[0];
    status_expect = lfsr[15:8];
    control_expect = lfsr[7:0];
    host_write(self_test_pkg::test_select_addr, {8'h00, t});
    repeat (3) @(negedge mclk);
    n = 0;
    while (test_busy !== 1'b0 && n < 3000)
    begin
        @(negedge mclk);
        n++;
    end
    check({15'h0000, test_busy}, 16'h0000);
    check({8'h00, fail_code}, {8'h00, exp});
    check(fail_code_ext, model_ext(exp));
    repeat (5) @(negedge mclk);
    check({8'h00, fail_code}, {8'h00, exp});
    if (t == 8'h0a)
        check({12'h000, stoe_hi, stoe_lo, high_latch_en, low_latch_en}, 16'h000a);
    if (t == 8'h0d)
        host_read(self_test_pkg::last_status_addr, {8'h00, status_expect ^ {8{f == 4'h6 || f == 4'h8}}}, 1'b1);
endtask
task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// ==========
// Clock and watchdog
initial
begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
end
always @(posedge mclk)
begin
    cycles++;
    if (cycles == 80000)
    begin
        num_errors++;
        test_done();
    end
end
// ==========
// Main sequence
initial
begin
    {host_wr, host_rd, low_power, slow} = 4'h0;
    host_addr = 32'h0000_0000;
    host_wdata = 16'h0000;
    {status_expect, control_expect} = 16'h0000;
    fault = 4'h0;
    lfsr = 16'd12525;
    {num_errors, cmp_count, cycles} = {32'd0, 32'd0, 32'd0};
    reset = 1'b1;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    host_write(self_test_pkg::self_test_ctl_addr, self_test_pkg::self_test_off);
    @(negedge mclk);
    check({15'h0000, self_test_enabled}, 16'h0000);
    host_write(self_test_pkg::self_test_ctl_addr, self_test_pkg::self_test_on);
    @(negedge mclk);
    check({15'h0000, self_test_enabled}, 16'h0001);
    foreach (runs[i])
        run_test(runs[i][15:8], runs[i][3:0]);
    low_power = 1'b1;
    repeat (8) @(negedge mclk);
    check({15'h0000, host_data_oe}, 16'h0000);
    host_read(self_test_pkg::last_status_addr, 16'h0000, 1'b0);
    low_power = 1'b0;
    test_done();
end
endmodule
